/* ssf_pkg.sv */
// Shared constants, field positions and helpers of the status flag reporter
`default_nettype none
package ssf_pkg;
    localparam int                     LIN_COUNT      = 2;
    localparam int                     FLAG_W         = 6;
    localparam int                     WORD_W         = 16;
    localparam int                     CNT_W          = 5;
    localparam int                     SYNC_W         = 3;
    // Local net flag byte positions
    localparam int                     FL_WAKE        = 5;
    localparam int                     FL_TERM        = 4;
    localparam int                     FL_OTEMP       = 3;
    localparam int                     FL_RXL         = 2;
    localparam int                     FL_RXH         = 1;
    localparam int                     FL_TXD         = 0;
    // Fixed status word positions
    localparam int                     ST_INT         = 15;
    localparam int                     ST_WAKE        = 14;
    localparam int                     ST_RST         = 13;
    localparam int                     ST_CAN_G       = 12;
    localparam int                     ST_LNET_G      = 11;
    localparam int                     ST_IO_G        = 10;
    localparam int                     ST_SAFE_G      = 9;
    localparam int                     ST_SUP_G       = 8;
    localparam int                     ST_CAN_BUS     = 7;
    localparam int                     ST_CANBUS_LOCAL_SOURCE     = 6;
    localparam int                     ST_LNET2       = 5;
    localparam int                     ST_LNET1       = 4;
    localparam int                     ST_IO_HI       = 3;
    localparam int                     ST_IO_LO       = 2;
    localparam int                     ST_SUP_HI      = 1;
    localparam int                     ST_SUP_LO      = 0;
    // Command decode
    localparam logic [1:0]             CMD_WRITE      = 2'h1;
    localparam logic [7:0]             FLAG_RD1_HI    = 8'h27;
    localparam logic [7:0]             FLAG_RD2_HI    = 8'h29;
    localparam logic [7:0]             FLAG_RD_LO     = 8'h80;
    // Frame bit counts
    localparam logic [CNT_W-1:0]       BITS_PER_FRAME = 5'h10;
    localparam logic [CNT_W-1:0]       HI_BYTE_BITS   = 5'h08;
    localparam logic [CNT_W-1:0]       CNT_MAX        = 5'h11;
    // Reset values
    localparam logic [SYNC_W-1:0]      CSB_SYNC_RST   = 3'h7;
    localparam logic                   EPOCH_RST      = 1'b1;
    localparam logic                   OE_N_RST       = 1'b1;
    // Select timing around the serial clock
    localparam int                     CLK_MHZ        = 200;
    localparam int                     CS_LEAD_NS     = 30;
    localparam int                     CS_LAG_NS      = 30;
    localparam int                     CS_LEAD_CYC    = (CS_LEAD_NS * CLK_MHZ + 999) / 1000;
    localparam int                     CS_LAG_CYC     = (CS_LAG_NS * CLK_MHZ + 999) / 1000;

    // Second response byte chosen from the command high byte
    function automatic logic [7:0] ssf_low_byte(
        input logic [7:0]        cmd_hi,
        input logic [7:0]        status_lo,
        input logic [FLAG_W-1:0] fl1,
        input logic [FLAG_W-1:0] fl2
    );
        logic [7:0] res;
        res = 8'h00;
        if (cmd_hi[7:6] == CMD_WRITE) begin
            res = status_lo;
        end else if (cmd_hi == FLAG_RD1_HI) begin
            res = {2'h0, fl1};
        end else if (cmd_hi == FLAG_RD2_HI) begin
            res = {2'h0, fl2};
        end
        return res;
    endfunction : ssf_low_byte
endpackage : ssf_pkg
`default_nettype wire

/* ssf_link_if.sv */
// Signals between the core clock side and the serial clock side
`default_nettype none
interface ssf_link_if;
    import ssf_pkg::*;
    logic [WORD_W-1:0]                 snap_word;
    logic [LIN_COUNT-1:0][FLAG_W-1:0]  snap_flags;
    logic                              epoch;
    logic                              done_tgl;
    logic [WORD_W-1:0]                 cmd_word;
    logic                              miso;
    modport core (output snap_word, output snap_flags, output epoch,
                  input done_tgl, input cmd_word, input miso);
    modport link (input snap_word, input snap_flags, input epoch,
                  output done_tgl, output cmd_word, output miso);
endinterface : ssf_link_if
`default_nettype wire

/* ssf_link.sv */
// Serial clock side: shifts the command in and the status response out
`default_nettype none
module ssf_link
    import ssf_pkg::*;
(
    input  wire logic     sclk,
    input  wire logic     nrst,
    input  wire logic     mosi,
    ssf_link_if.link      lk
);
    typedef struct packed {
        logic              seen_epoch;
        logic [CNT_W-1:0]  cnt;
        logic [WORD_W-1:0] rx;
        logic [7:0]        lo;
        logic              miso;
        logic              done_tgl;
        logic [WORD_W-1:0] cmd;
    } ssf_link_s;

    ssf_link_s          st_reg;
    ssf_link_s          st_next;
    logic [CNT_W-1:0]   n;
    logic [CNT_W-1:0]   idx;
    logic [WORD_W-1:0]  rx_n;
    logic [7:0]         lo_n;

    always_comb begin
        st_next = st_reg;
        lo_n    = ssf_low_byte(st_reg.rx[7:0], lk.snap_word[7:0], lk.snap_flags[0], lk.snap_flags[1]);
        if (st_reg.seen_epoch != lk.epoch) begin
            n = 5'h01;
        end else if (st_reg.cnt == CNT_MAX) begin
            n = CNT_MAX;
        end else begin
            n = st_reg.cnt + 5'h01;
        end
        idx                = BITS_PER_FRAME - n;
        rx_n               = {st_reg.rx[WORD_W-2:0], mosi};
        st_next.seen_epoch = lk.epoch;
        st_next.cnt        = n;
        st_next.rx         = rx_n;
        st_next.miso       = 1'b0;
        if (n <= HI_BYTE_BITS) begin
            st_next.miso = lk.snap_word[idx[3:0]];
        end else if (n == HI_BYTE_BITS + 5'h01) begin
            st_next.lo   = lo_n;
            st_next.miso = lo_n[7];
        end else if (n <= BITS_PER_FRAME) begin
            st_next.miso = st_reg.lo[idx[2:0]];
        end
        if (n == BITS_PER_FRAME) begin
            st_next.cmd      = rx_n;
            st_next.done_tgl = ~st_reg.done_tgl;
        end
    end

    always_ff @(posedge sclk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign lk.miso     = st_reg.miso;
    assign lk.done_tgl = st_reg.done_tgl;
    assign lk.cmd_word = st_reg.cmd;

    first_bit_a: assert property (@(posedge sclk) disable iff (!nrst)
        (st_reg.seen_epoch != lk.epoch) |=> st_reg.miso == $past(lk.snap_word[ST_INT]))
        else $error("first response bit is not status bit 15");
    write_ext_a: assert property (@(posedge sclk) disable iff (!nrst)
        (n == 5'h09 && st_reg.rx[7:6] == CMD_WRITE) |=> st_reg.lo == $past(lk.snap_word[7:0]))
        else $error("write command did not return extended status");
    read_one_a: assert property (@(posedge sclk) disable iff (!nrst)
        (n == 5'h09 && st_reg.rx[7:6] != CMD_WRITE && st_reg.rx[7:0] != FLAG_RD1_HI
         && st_reg.rx[7:0] != FLAG_RD2_HI) |=> st_reg.lo == 8'h00)
        else $error("read command returned more than fixed status");
    frame_done_a: assert property (@(posedge sclk) disable iff (!nrst)
        (n == BITS_PER_FRAME) |=> st_reg.done_tgl != $past(st_reg.done_tgl))
        else $error("complete frame not reported");
endmodule : ssf_link
`default_nettype wire

/* ssf_top.sv */
// Local net diagnostic flags and fixed status word behind the serial port
//
// Behaviour
// - Wake flag sets on wake, clears on read
// - Termination short flag clears after recovery and read
// - Overtemp flag clears when cool and read
// - Receive stuck low clears after recovery, read
// - Receive stuck high clears after recovery, read
// - Transmit dominant clears after recovery, read
// - Every command shifts out fixed status
// - Write command returns status plus extended byte
// - Read command returns only fixed status byte, except flag reads 0x27 and 0x29, which return that net's flag byte
// - Bit 15 shows pending interrupt flags
// - Bit 14 shows pending wake flags
// - Bit 13 shows pending reset cause flags
// - Bits 12 to 8 show source groups
// - Bits 7, 6 show bus, local sources
// - Bits 5, 4 show second, first net
// - Bits 3, 2 show high, low sub-address
// - Bits 1, 0 show supply sub-addresses
`default_nettype none
module ssf_top
    import ssf_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire logic                  sclk,
    input  wire logic                  csb_n,
    input  wire logic                  mosi,
    input  wire logic [LIN_COUNT-1:0]  lnet_wake_evt,
    input  wire logic [LIN_COUNT-1:0]  lnet_term_short,
    input  wire logic [LIN_COUNT-1:0]  lnet_overtemp,
    input  wire logic [LIN_COUNT-1:0]  lnet_rxd_low,
    input  wire logic [LIN_COUNT-1:0]  lnet_rxd_high,
    input  wire logic [LIN_COUNT-1:0]  lnet_txd_dom,
    input  wire logic                  ext_int_pend,
    input  wire logic                  ext_wake_pend,
    input  wire logic                  ext_rst_pend,
    input  wire logic                  canbus_bus_source,
    input  wire logic                  canbus_local_source,
    input  wire logic                  io_high_source,
    input  wire logic                  io_low_source,
    input  wire logic                  safe_source,
    input  wire logic                  supply_high_subaddr_source,
    input  wire logic                  supply_low_subaddr_source,
    output logic                       miso,
    output logic                       miso_oe_n,
    output logic [WORD_W-1:0]          status_word
);
    typedef struct packed {
        logic [SYNC_W-1:0]                 csb_sync;
        logic [SYNC_W-1:0]                 done_sync;
        logic                              csb_stable;
        logic                              done_seen;
        logic                              frame_ok;
        logic                              epoch;
        logic                              oe_n;
        logic [WORD_W-1:0]                 snap_word;
        logic [LIN_COUNT-1:0][FLAG_W-1:0]  snap_flags;
        logic [LIN_COUNT-1:0][FLAG_W-1:0]  flags;
    } ssf_core_s;

    ssf_core_s                          st_reg;
    ssf_core_s                          st_next;
    ssf_link_if                         lk ();
    logic [LIN_COUNT-1:0][FLAG_W-1:0]   cond;
    logic [LIN_COUNT-1:0][FLAG_W-1:0]   clr;
    logic [LIN_COUNT-1:0]               rd;
    logic [LIN_COUNT-1:0]               lnet_src;
    logic [LIN_COUNT-1:0]               lnet_fault;
    logic [LIN_COUNT-1:0]               lnet_wake;
    logic [WORD_W-1:0]                  status_w;
    logic                               done_evt;
    logic                               frame_end;
    logic                               csb_next;
    logic                               wake_pending;
    logic                               supply_group_source;
    logic                               canbus_group_source;
    logic                               first_local_net_source;
    logic                               second_local_net_source;
    logic [1:0]                         command_type_field;

    ssf_link u_link (
        .sclk (sclk),
        .nrst (nrst),
        .mosi (mosi),
        .lk   (lk.link)
    );

    // Per net flag conditions in flag byte order
    always_comb begin
        for (int k = 0; k < LIN_COUNT; k++) begin
            cond[k] = {lnet_wake_evt[k], lnet_term_short[k], lnet_overtemp[k],
                       lnet_rxd_low[k], lnet_rxd_high[k], lnet_txd_dom[k]};
        end
    end

    // Summary and source bits of the status word
    always_comb begin
        for (int k = 0; k < LIN_COUNT; k++) begin
            lnet_src[k]   = |st_reg.flags[k];
            lnet_wake[k]  = st_reg.flags[k][FL_WAKE];
            lnet_fault[k] = |(st_reg.flags[k] & ~(FLAG_W'(1) << FL_WAKE));
        end
        first_local_net_source  = lnet_src[0];
        second_local_net_source = lnet_src[1];
        wake_pending            = ext_wake_pend | (|lnet_wake);
        supply_group_source     = supply_high_subaddr_source | supply_low_subaddr_source;
        canbus_group_source     = canbus_bus_source | canbus_local_source;
        status_w                = '0;
        status_w[ST_INT]        = ext_int_pend | (|lnet_fault);
        status_w[ST_WAKE]       = wake_pending;
        status_w[ST_RST]        = ext_rst_pend;
        status_w[ST_CAN_G]      = canbus_group_source;
        status_w[ST_LNET_G]     = first_local_net_source | second_local_net_source;
        status_w[ST_IO_G]       = io_high_source | io_low_source;
        status_w[ST_SAFE_G]     = safe_source;
        status_w[ST_SUP_G]      = supply_group_source;
        status_w[ST_CAN_BUS]    = canbus_bus_source;
        status_w[ST_CANBUS_LOCAL_SOURCE]    = canbus_local_source;
        status_w[ST_LNET2]      = second_local_net_source;
        status_w[ST_LNET1]      = first_local_net_source;
        status_w[ST_IO_HI]      = io_high_source;
        status_w[ST_IO_LO]      = io_low_source;
        status_w[ST_SUP_HI]     = supply_high_subaddr_source;
        status_w[ST_SUP_LO]     = supply_low_subaddr_source;
    end

    // Frame tracking, flag update and snapshot
    always_comb begin
        st_next            = st_reg;
        st_next.csb_sync   = {st_reg.csb_sync[SYNC_W-2:0], csb_n};
        st_next.done_sync  = {st_reg.done_sync[SYNC_W-2:0], lk.done_tgl};
        csb_next           = (st_reg.csb_sync[1] == st_reg.csb_sync[2]) ? st_reg.csb_sync[2] : st_reg.csb_stable;
        done_evt           = (st_reg.done_sync[1] == st_reg.done_sync[2])
                             && (st_reg.done_sync[2] != st_reg.done_seen);
        frame_end          = !st_reg.csb_stable && csb_next;
        command_type_field = lk.cmd_word[WORD_W-1:WORD_W-2];
        st_next.csb_stable = csb_next;
        st_next.oe_n       = csb_next;
        if (done_evt) begin
            st_next.done_seen = st_reg.done_sync[2];
            st_next.frame_ok  = 1'b1;
        end
        rd    = '0;
        if (frame_end) begin
            st_next.frame_ok = 1'b0;
            st_next.epoch    = ~st_reg.epoch;
            if ((st_reg.frame_ok || done_evt) && command_type_field != CMD_WRITE) begin
                rd[0] = lk.cmd_word == {FLAG_RD1_HI, FLAG_RD_LO};
                rd[1] = lk.cmd_word == {FLAG_RD2_HI, FLAG_RD_LO};
            end
        end
        for (int k = 0; k < LIN_COUNT; k++) begin
            // Only flags that were shifted out may clear; fault flags also need recovery
            clr[k]          = {FLAG_W{rd[k]}} & st_reg.snap_flags[k] & ~cond[k];
            clr[k][FL_WAKE] = rd[k] & st_reg.snap_flags[k][FL_WAKE];
            // Set wins over clear
            st_next.flags[k] = cond[k] | (st_reg.flags[k] & ~clr[k]);
        end
        // Snapshot frozen while selected so the serial side sees stable words
        if (st_reg.csb_stable && csb_next) begin
            st_next.snap_word  = status_w;
            st_next.snap_flags = st_reg.flags;
        end
        if (!nrst) begin
            st_next            = '0;
            st_next.csb_sync   = CSB_SYNC_RST;
            st_next.csb_stable = 1'b1;
            st_next.epoch      = EPOCH_RST;
            st_next.oe_n       = OE_N_RST;
        end
    end

    always_ff @(posedge clk) begin
        st_reg <= st_next;
    end

    assign lk.snap_word  = st_reg.snap_word;
    assign lk.snap_flags = st_reg.snap_flags;
    assign lk.epoch      = st_reg.epoch;
    assign miso          = lk.miso;
    assign miso_oe_n     = st_reg.oe_n;
    assign status_word   = st_reg.snap_word;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_fault_read(int k, int b);
        rd[k] && st_reg.snap_flags[k][b];
    endsequence
    sequence s_flag_gone(int k, int b);
        ##1 !st_reg.flags[k][b];
    endsequence

    wake_set_a: assert property (lnet_wake_evt[0] |=> st_reg.flags[0][FL_WAKE])
        else $error("wake flag not set");
    wake_clear_a: assert property (s_fault_read(1, FL_WAKE) ##0 !lnet_wake_evt[1] |-> s_flag_gone(1, FL_WAKE))
        else $error("wake flag not cleared by read");
    term_keep_a: assert property (st_reg.flags[0][FL_TERM] && lnet_term_short[0] |=> st_reg.flags[0][FL_TERM])
        else $error("termination flag cleared during failure");
    otemp_clear_a: assert property (s_fault_read(1, FL_OTEMP) ##0 !lnet_overtemp[1] |-> s_flag_gone(1, FL_OTEMP))
        else $error("overtemp flag not cleared after cooling and read");
    rxlow_keep_a: assert property (st_reg.flags[0][FL_RXL] && !rd[0] |=> st_reg.flags[0][FL_RXL])
        else $error("receive low flag lost without read");
    rxhigh_set_a: assert property (lnet_rxd_high[1] |=> st_reg.flags[1][FL_RXH])
        else $error("receive high flag not set");
    txdom_clear_a: assert property (s_fault_read(0, FL_TXD) ##0 !lnet_txd_dom[0] |-> s_flag_gone(0, FL_TXD))
        else $error("transmit dominant flag not cleared");
    snap_track_a: assert property (st_reg.csb_stable && csb_next |=> st_reg.snap_word == $past(status_w))
        else $error("snapshot does not follow status while idle");
    int_bit_a: assert property (st_reg.flags[0][FL_TERM] |-> status_w[ST_INT] && status_w[ST_LNET_G])
        else $error("fault flag not shown as interrupt");
    wake_bit_a: assert property (st_reg.flags[1][FL_WAKE] |-> status_w[ST_WAKE] && status_w[ST_LNET2])
        else $error("wake flag not shown in status");
    rst_bit_a: assert property (ext_rst_pend |-> status_w[ST_RST])
        else $error("reset pending not shown");
    group_bits_a: assert property (safe_source || canbus_bus_source |-> status_w[ST_SAFE_G] || status_w[ST_CAN_G])
        else $error("group bit missing");
    can_bits_a: assert property (canbus_local_source |-> status_w[ST_CANBUS_LOCAL_SOURCE] && status_w[ST_CAN_G])
        else $error("local bus source not shown");
    net1_bit_a: assert property (st_reg.flags[0] != '0 |-> status_w[ST_LNET1] && !status_w[ST_LNET2] == (st_reg.flags[1] == '0))
        else $error("net source bits wrong");
    io_bits_a: assert property (io_high_source && !io_low_source |-> status_w[ST_IO_HI] && !status_w[ST_IO_LO])
        else $error("io sub-address bits wrong");
    supply_bits_a: assert property (supply_low_subaddr_source |-> status_w[ST_SUP_LO] && status_w[ST_SUP_G])
        else $error("supply sub-address bits wrong");
    idle_zero_a: assert property (st_reg.flags == '0 && !ext_int_pend && !ext_wake_pend && !ext_rst_pend
        && !canbus_group_source && !io_high_source && !io_low_source && !safe_source && !supply_group_source
        |-> status_w == '0)
        else $error("status bit set with nothing pending");
    epoch_flip_a: assert property (frame_end |=> st_reg.epoch != $past(st_reg.epoch) ##1 st_reg.oe_n)
        else $error("frame end not closed");
endmodule : ssf_top
`default_nettype wire

/* ssf_host_model.sv */
// Host serial master model: select, serial clock and command data
`default_nettype none
module ssf_host_model (
    output logic      sclk,
    output logic      csb_n,
    output logic      mosi,
    input  wire logic miso
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        sclk  = 1'b0;
        csb_n = 1'b1;
        mosi  = 1'b0;
    end

    // Full frame, clock still outside it, data sampled on falling edge
    task automatic xfer(input logic [15:0] cmd, output logic [15:0] rsp);
        csb_n = 1'b0;
        #40;
        for (int i = 15; i >= 0; i--) begin
            mosi = cmd[i];
            #15 sclk = 1'b1;
            #15 sclk = 1'b0;
            rsp[i] = miso;
        end
        #40 csb_n = 1'b1;
        mosi = ~mosi;
        #120;
    endtask : xfer
endmodule : ssf_host_model
`default_nettype wire

/* tb_top.sv */
// Self-checking bench of the status flag reporter
`default_nettype none
module tb_top
    import ssf_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic                 clk;
    logic                 nrst;
    logic                 sclk;
    logic                 csb_n;
    logic                 mosi;
    logic                 miso;
    logic                 miso_oe_n;
    logic [WORD_W-1:0]    status_word;
    logic [9:0]           pins;
    logic [LIN_COUNT-1:0] flt [6];
    logic [15:0]          rsp;
    logic [15:0]          cmd;
    logic [15:0]          ew;
    int                   errors;
    int                   compares;

    ssf_top i_dut (
        .clk                        (clk),
        .nrst                       (nrst),
        .sclk                       (sclk),
        .csb_n                      (csb_n),
        .mosi                       (mosi),
        .lnet_wake_evt              (flt[FL_WAKE]),
        .lnet_term_short            (flt[FL_TERM]),
        .lnet_overtemp              (flt[FL_OTEMP]),
        .lnet_rxd_low               (flt[FL_RXL]),
        .lnet_rxd_high              (flt[FL_RXH]),
        .lnet_txd_dom               (flt[FL_TXD]),
        .ext_int_pend               (pins[9]),
        .ext_wake_pend              (pins[8]),
        .ext_rst_pend               (pins[7]),
        .canbus_bus_source          (pins[6]),
        .canbus_local_source        (pins[5]),
        .io_high_source             (pins[4]),
        .io_low_source              (pins[3]),
        .safe_source                (pins[2]),
        .supply_high_subaddr_source (pins[1]),
        .supply_low_subaddr_source  (pins[0]),
        .miso                       (miso),
        .miso_oe_n                  (miso_oe_n),
        .status_word                (status_word)
    );

    ssf_host_model i_host (
        .sclk  (sclk),
        .csb_n (csb_n),
        .mosi  (mosi),
        .miso  (miso)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_sim;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    // Expected word from one pattern of pending and source levels
    function automatic logic [15:0] exp_word(input logic [9:0] v);
        return {v[9:7], v[6] | v[5], 1'b0, v[4] | v[3], v[2], v[1] | v[0],
                v[6], v[5], 2'h0, v[4], v[3], v[1], v[0]};
    endfunction : exp_word

    initial begin
        #100000;
        errors++;
        end_sim();
    end

    initial begin
        nrst = 1'b0;
        pins = 10'h000;
        for (int p = 0; p < 6; p++) flt[p] = 2'h0;
        repeat (6) @(posedge clk);
        chk(status_word, 16'h0000);
        chk({15'h0, miso_oe_n}, 16'h0001);
        nrst <= 1'b1;
        repeat (8) @(posedge clk);
        // Each source alone, every command type in turn
        for (int k = 0; k < 10; k++) begin
            @(posedge clk) pins <= 10'h001 << k;
            repeat (4) @(posedge clk);
            ew = exp_word(10'h001 << k);
            chk(status_word, ew);
            cmd = (k % 4 == 0) ? 16'h4000 : (k % 4 == 1) ? 16'h0000 : (k % 4 == 2) ? 16'hC000 : 16'h8000;
            i_host.xfer(cmd, rsp);
            chk(rsp[15:8], ew[15:8]);
            chk(rsp[7:0], (cmd[15:14] == CMD_WRITE) ? ew[7:0] : 8'h00);
            chk({15'h0, miso_oe_n}, 16'h0001);
        end
        @(posedge clk) pins <= 10'h000;
        // Each flag of each net: set, read while present (except wake, pulsed first), recover, read
        for (int n = 0; n < LIN_COUNT; n++) begin
            cmd = (n == 0) ? 16'h2780 : 16'h2980;
            for (int p = 0; p < 6; p++) begin
                @(posedge clk) flt[p][n] <= 1'b1;
                if (p == FL_WAKE) @(posedge clk) flt[p][n] <= 1'b0;
                repeat (4) @(posedge clk);
                chk({15'h0, status_word[ST_LNET1 + n]}, 16'h0001);
                chk({15'h0, status_word[ST_LNET_G]}, 16'h0001);
                if (p == FL_WAKE) chk({15'h0, status_word[ST_WAKE]}, 16'h0001);
                if (p != FL_WAKE) begin
                    i_host.xfer(cmd, rsp);
                    chk(rsp[7:0], 8'h01 << p);
                    @(posedge clk) flt[p][n] <= 1'b0;
                end
                i_host.xfer(cmd, rsp);
                chk(rsp[7:0], 8'h01 << p);
                i_host.xfer(cmd, rsp);
                chk(rsp[7:0], 8'h00);
                chk(status_word, 16'h0000);
            end
        end
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
